// file: logic/accr_regs.sv
// APB register bank: detect threshold low byte, DC filter select and channel 0 settings.
//
// Operation
// - Threshold low byte sits in bits 15:8 of shared word, read/write, resets zero.
// - Filter code zero disables; codes 1 to 14 give coefficient 1/4 halving to 1/32768.
// - Channel 0 bit 2 set disables DC filtering for channel 0 only.
// - Channel 0 bits 15:6 are a signed ten-bit phase delay in modulator cycles.
// - Input select: 00 normal pair, 01 shorted, 10 positive test, 11 negative test.
// - Offset calibration bits 23:8 held in full sixteen-bit read/write word, reset zero.
// - Offset calibration bits 7:0 in bits 15:8 of next word; low byte reads zero.
//
// Register access over APB was chosen for this implementation.
module accr_regs
  import accr_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // Settings to the datapath
  output logic [15:0]      DETECT_THRESHOLD_LOW_BYTE_WORD,
  output logic             CH0_DC_FILTER_ENABLE,
  output logic [3:0]       CH0_DC_FILTER_SHIFT,
  output logic signed [9:0] CHANNEL0_PHASE_DELAY,
  output logic [1:0]       CHANNEL0_INPUT_SELECT,
  output logic [23:0]      CHANNEL0_OFFSET_CAL
);

  // ********************
  // Bus decode
  // ********************
  logic        access;
  logic        wr_en;
  logic        wr_thresh_filt;
  logic        wr_ch0_config;
  logic        wr_ocal_high;
  logic        wr_ocal_low;
  logic        hit;
  logic [31:0] rd_next;
  logic [7:0]  detect_threshold_low_byte_reg;
  logic [3:0]  dc_filter_coefficient_select_reg;
  logic [9:0]  channel0_phase_delay_reg;
  logic        channel0_dc_filter_disable_reg;
  logic [1:0]  channel0_input_select_reg;
  logic [15:0] offset_cal_high_field_reg;
  logic [7:0]  offset_cal_low_field_reg;

  // The slave answers in the first access cycle, so every transfer takes two cycles.
  assign access = PSEL && PENABLE;
  assign wr_en  = access && PWRITE;

  // One strobe per word keeps the address compare out of the storage processes.
  assign wr_thresh_filt = wr_en && (PADDR == ACCR_ADDR_THRESH_FILT);
  assign wr_ch0_config  = wr_en && (PADDR == ACCR_ADDR_CH0_CONFIG);
  assign wr_ocal_high   = wr_en && (PADDR == ACCR_ADDR_CH0_OCAL_HI);
  assign wr_ocal_low    = wr_en && (PADDR == ACCR_ADDR_CH0_OCAL_LO);

  always_comb begin
    hit     = 1'b1;
    rd_next = 32'h0000_0000;
    unique case (PADDR)
      ACCR_ADDR_THRESH_FILT: begin
        rd_next[ACCR_TH_MSB:ACCR_TH_LSB]   = detect_threshold_low_byte_reg;
        rd_next[ACCR_DCF_MSB:ACCR_DCF_LSB] = dc_filter_coefficient_select_reg;
      end
      ACCR_ADDR_CH0_CONFIG: begin
        rd_next[ACCR_PHASE_MSB:ACCR_PHASE_LSB] = channel0_phase_delay_reg;
        rd_next[ACCR_DCDIS_BIT]                = channel0_dc_filter_disable_reg;
        rd_next[ACCR_MUX_MSB:ACCR_MUX_LSB]     = channel0_input_select_reg;
      end
      ACCR_ADDR_CH0_OCAL_HI: begin
        rd_next[15:0] = offset_cal_high_field_reg;
      end
      ACCR_ADDR_CH0_OCAL_LO: begin
        rd_next[ACCR_OCLO_MSB:ACCR_OCLO_LSB] = offset_cal_low_field_reg;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ********************
  // Registers
  // ********************
  // Only named field bits are stored; reserved bits have no flops, so writes vanish.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      detect_threshold_low_byte_reg <= ACCR_RST_TH;
    end else if (wr_thresh_filt) begin
      detect_threshold_low_byte_reg <= PWDATA[ACCR_TH_MSB:ACCR_TH_LSB];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dc_filter_coefficient_select_reg <= ACCR_RST_DCF;
    end else if (wr_thresh_filt) begin
      dc_filter_coefficient_select_reg <= PWDATA[ACCR_DCF_MSB:ACCR_DCF_LSB];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      channel0_phase_delay_reg <= ACCR_RST_PHASE;
    end else if (wr_ch0_config) begin
      channel0_phase_delay_reg <= PWDATA[ACCR_PHASE_MSB:ACCR_PHASE_LSB];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      channel0_dc_filter_disable_reg <= ACCR_RST_DCDIS;
    end else if (wr_ch0_config) begin
      channel0_dc_filter_disable_reg <= PWDATA[ACCR_DCDIS_BIT];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      channel0_input_select_reg <= ACCR_RST_MUX;
    end else if (wr_ch0_config) begin
      channel0_input_select_reg <= PWDATA[ACCR_MUX_MSB:ACCR_MUX_LSB];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      offset_cal_high_field_reg <= ACCR_RST_OCHI;
    end else if (wr_ocal_high) begin
      offset_cal_high_field_reg <= PWDATA[15:0];
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      offset_cal_low_field_reg <= ACCR_RST_OCLO;
    end else if (wr_ocal_low) begin
      offset_cal_low_field_reg <= PWDATA[ACCR_OCLO_MSB:ACCR_OCLO_LSB];
    end
  end

  // ********************
  // Bus answer
  // ********************
  // Unmapped addresses answer with an error and zero data; nothing is stored.
  // The answer is registered from the setup cycle, so it stands in the first access cycle only.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
    end else begin
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rd_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= PSEL && !PENABLE && !hit;
    end
  end

  // ********************
  // Datapath settings
  // ********************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CH0_DC_FILTER_ENABLE <= 1'b0;
    end else begin
      // Code 15 is undefined; it is treated as off rather than a 1/65536 coefficient.
      CH0_DC_FILTER_ENABLE <= !channel0_dc_filter_disable_reg
                              && dc_filter_coefficient_select_reg != ACCR_DCF_OFF
                              && dc_filter_coefficient_select_reg <= ACCR_DCF_MAX;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CH0_DC_FILTER_SHIFT <= 4'h0;
    end else begin
      // Shift of n+1 gives coefficient 2^-(n+1): code 1 is 1/4 up to code 14 at 1/32768.
      CH0_DC_FILTER_SHIFT <= dc_filter_coefficient_select_reg + ACCR_DCF_SHIFT0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DETECT_THRESHOLD_LOW_BYTE_WORD <= {ACCR_RST_TH, 8'h00};
    end else begin
      DETECT_THRESHOLD_LOW_BYTE_WORD <= {detect_threshold_low_byte_reg, 8'h00};
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CHANNEL0_PHASE_DELAY <= $signed(ACCR_RST_PHASE);
    end else begin
      CHANNEL0_PHASE_DELAY <= $signed(channel0_phase_delay_reg);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CHANNEL0_INPUT_SELECT <= ACCR_MUX_NORMAL;
    end else begin
      CHANNEL0_INPUT_SELECT <= channel0_input_select_reg;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CHANNEL0_OFFSET_CAL <= {ACCR_RST_OCHI, ACCR_RST_OCLO};
    end else begin
      CHANNEL0_OFFSET_CAL <= {offset_cal_high_field_reg, offset_cal_low_field_reg};
    end
  end

endmodule // accr_regs

// file: logic/accr_pkg.sv
// Package with register map, field layout and decode constants for the channel config bank.
package accr_pkg;

  // ********************
  // Register indices and byte addresses
  // ********************
  localparam int unsigned ACCR_IDX_THRESH_FILT = 8;
  localparam int unsigned ACCR_IDX_CH0_CONFIG  = 9;
  localparam int unsigned ACCR_IDX_CH0_OCAL_HI = 10;
  localparam int unsigned ACCR_IDX_CH0_OCAL_LO = 11;
  localparam logic [11:0] ACCR_ADDR_THRESH_FILT = 12'(ACCR_IDX_THRESH_FILT * 4);
  localparam logic [11:0] ACCR_ADDR_CH0_CONFIG  = 12'(ACCR_IDX_CH0_CONFIG * 4);
  localparam logic [11:0] ACCR_ADDR_CH0_OCAL_HI = 12'(ACCR_IDX_CH0_OCAL_HI * 4);
  localparam logic [11:0] ACCR_ADDR_CH0_OCAL_LO = 12'(ACCR_IDX_CH0_OCAL_LO * 4);

  // ********************
  // Field positions
  // ********************
  localparam int unsigned ACCR_TH_LSB      = 8;
  localparam int unsigned ACCR_TH_MSB      = 15;
  localparam int unsigned ACCR_DCF_LSB     = 0;
  localparam int unsigned ACCR_DCF_MSB     = 3;
  localparam int unsigned ACCR_PHASE_LSB   = 6;
  localparam int unsigned ACCR_PHASE_MSB   = 15;
  localparam int unsigned ACCR_DCDIS_BIT   = 2;
  localparam int unsigned ACCR_MUX_LSB     = 0;
  localparam int unsigned ACCR_MUX_MSB     = 1;
  localparam int unsigned ACCR_OCLO_LSB    = 8;
  localparam int unsigned ACCR_OCLO_MSB    = 15;

  // ********************
  // Reset values
  // ********************
  localparam logic [7:0]  ACCR_RST_TH    = 8'h00;
  localparam logic [3:0]  ACCR_RST_DCF   = 4'h0;
  localparam logic [9:0]  ACCR_RST_PHASE = 10'h000;
  localparam logic        ACCR_RST_DCDIS = 1'b0;
  localparam logic [1:0]  ACCR_RST_MUX   = 2'h0;
  localparam logic [15:0] ACCR_RST_OCHI  = 16'h0000;
  localparam logic [7:0]  ACCR_RST_OCLO  = 8'h00;

  // ********************
  // Decode values
  // ********************
  localparam logic [3:0] ACCR_DCF_OFF     = 4'h0;
  localparam logic [3:0] ACCR_DCF_MAX     = 4'hE;
  localparam logic [3:0] ACCR_DCF_SHIFT0  = 4'h1;

  typedef enum logic [1:0] {
    ACCR_MUX_NORMAL  = 2'h0,
    ACCR_MUX_SHORTED = 2'h1,
    ACCR_MUX_TEST_POS = 2'h2,
    ACCR_MUX_TEST_NEG = 2'h3
  } accr_mux_t;

endpackage

// file: testbench/accr_chk_assertions.sv
// Checker for the channel config bank, seeing only its ports.
module accr_chk
  import accr_pkg::*;
(
  // Bus
  input logic              CLK,
  input logic              RESET_N,
  input logic              PSEL,
  input logic              PENABLE,
  input logic              PWRITE,
  input logic [11:0]       PADDR,
  input logic [31:0]       PWDATA,
  input logic              PREADY,
  input logic [31:0]       PRDATA,
  input logic              PSLVERR,
  // Settings
  input logic [15:0]       DETECT_THRESHOLD_LOW_BYTE_WORD,
  input logic              CH0_DC_FILTER_ENABLE,
  input logic [3:0]        CH0_DC_FILTER_SHIFT,
  input logic signed [9:0] CHANNEL0_PHASE_DELAY,
  input logic [1:0]        CHANNEL0_INPUT_SELECT,
  input logic [23:0]       CHANNEL0_OFFSET_CAL
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic rd;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  assign rd = PSEL && PENABLE && PREADY && !PWRITE;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ****
  // Settings are checked two edges on, which holds whether they lag by zero or one.
  // ****
  a_thr_write: assert property (wr && PADDR == ACCR_ADDR_THRESH_FILT |=> ##1
    DETECT_THRESHOLD_LOW_BYTE_WORD == {$past(PWDATA[15:8], 2), 8'h00}) else $error("thr");
  a_dc_off: assert property (wr && PADDR == ACCR_ADDR_THRESH_FILT &&
    PWDATA[3:0] inside {4'h0, 4'hF} |=> ##1 !CH0_DC_FILTER_ENABLE) else $error("dc off");
  a_dc_shift: assert property (wr && PADDR == ACCR_ADDR_THRESH_FILT |=> ##1
    !CH0_DC_FILTER_ENABLE || CH0_DC_FILTER_SHIFT == $past(PWDATA[3:0], 2) + 4'h1)
    else $error("dc shift");
  a_ch0_dis: assert property (wr && PADDR == ACCR_ADDR_CH0_CONFIG && PWDATA[2] |=> ##1
    !CH0_DC_FILTER_ENABLE) else $error("ch0 dis");
  a_ch0_config: assert property (wr && PADDR == ACCR_ADDR_CH0_CONFIG |=> ##1
    CHANNEL0_PHASE_DELAY == $past(PWDATA[15:6], 2) &&
    CHANNEL0_INPUT_SELECT == $past(PWDATA[1:0], 2)) else $error("channel0_config");
  a_ocal_hi: assert property (wr && PADDR == ACCR_ADDR_CH0_OCAL_HI |=> ##1
    CHANNEL0_OFFSET_CAL[23:8] == $past(PWDATA[15:0], 2)) else $error("ocal hi");
  a_ocal_lo: assert property (wr && PADDR == ACCR_ADDR_CH0_OCAL_LO |=> ##1
    CHANNEL0_OFFSET_CAL[7:0] == $past(PWDATA[15:8], 2)) else $error("ocal lo");
  a_rsv_read: assert property (rd && PADDR == ACCR_ADDR_CH0_CONFIG |->
    PRDATA[31:16] == 16'h0000 && PRDATA[5:3] == 3'h0) else $error("rsv");
  c_cfg: cover property (wr && PADDR == ACCR_ADDR_CH0_CONFIG);
  c_err: cover property (PREADY && PSLVERR);
  c_lo: cover property (rd && PADDR == ACCR_ADDR_CH0_OCAL_LO);
endmodule // accr_chk

bind accr_regs accr_chk u_chk (
  .CLK                            (CLK),
  .RESET_N                        (RESET_N),
  .PSEL                           (PSEL),
  .PENABLE                        (PENABLE),
  .PWRITE                         (PWRITE),
  .PADDR                          (PADDR),
  .PWDATA                         (PWDATA),
  .PREADY                         (PREADY),
  .PRDATA                         (PRDATA),
  .PSLVERR                        (PSLVERR),
  .DETECT_THRESHOLD_LOW_BYTE_WORD (DETECT_THRESHOLD_LOW_BYTE_WORD),
  .CH0_DC_FILTER_ENABLE           (CH0_DC_FILTER_ENABLE),
  .CH0_DC_FILTER_SHIFT            (CH0_DC_FILTER_SHIFT),
  .CHANNEL0_PHASE_DELAY           (CHANNEL0_PHASE_DELAY),
  .CHANNEL0_INPUT_SELECT          (CHANNEL0_INPUT_SELECT),
  .CHANNEL0_OFFSET_CAL            (CHANNEL0_OFFSET_CAL)
);

// file: testbench/accr_host.sv
// Host model that issues APB transfers to the register bank.
module accr_host (
  // Bus
  input  logic        clk,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input  logic        pready,
  input  logic [31:0] prdata,
  input  logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted so that a stale value cannot pass for a fresh one.
    pwdata <= ~d;
  endtask
endmodule // accr_host

// file: testbench/tb_accr_regs.sv
// Self-checking bench for the channel config register bank.
module tb_accr_regs
  import accr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              psel, penable, pwrite, pready, pslverr, dcen, e;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, q;
  logic [15:0]       thw;
  logic [3:0]        dcsh;
  logic [1:0]        isel;
  logic [23:0]       ocal;
  logic signed [9:0] phase;
  int                n_errors = 0;
  int                checks = 0;
  always #4 clk = ~clk;
  accr_regs u_dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .DETECT_THRESHOLD_LOW_BYTE_WORD(thw), .CH0_DC_FILTER_ENABLE(dcen),
    .CH0_DC_FILTER_SHIFT(dcsh), .CHANNEL0_PHASE_DELAY(phase),
    .CHANNEL0_INPUT_SELECT(isel), .CHANNEL0_OFFSET_CAL(ocal));
  accr_host u_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, e);
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic er);
    u_host.xfer(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", {31'h0, er}, {31'h0, e});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(ACCR_ADDR_THRESH_FILT, 32'h0, 1'b0);
    rd(ACCR_ADDR_CH0_CONFIG, 32'h0, 1'b0);
    rd(ACCR_ADDR_CH0_OCAL_HI, 32'h0, 1'b0);
    rd(ACCR_ADDR_CH0_OCAL_LO, 32'h0, 1'b0);
    $display("reset test done");
    wr(ACCR_ADDR_THRESH_FILT, 32'hFFFF_FFF5);
    rd(ACCR_ADDR_THRESH_FILT, 32'h0000_FF05, 1'b0);
    chk("thw", 32'h0000_FF00, {16'h0, thw});
    for (int c = 0; c < 16; c++) begin
      wr(ACCR_ADDR_THRESH_FILT, 32'(c));
      chk("dcen", 32'(c > 0 && c < 15), {31'h0, dcen});
      if (c > 0 && c < 15)
        chk("dcsh", 32'(c + 1), {28'h0, dcsh});
    end
    $display("filter test done");
    wr(ACCR_ADDR_THRESH_FILT, 32'h0000_0003);
    chk("dcen", 32'h1, {31'h0, dcen});
    wr(ACCR_ADDR_CH0_CONFIG, 32'hFFFF_FFFF);
    rd(ACCR_ADDR_CH0_CONFIG, 32'h0000_FFC7, 1'b0);
    chk("dcen", 32'h0, {31'h0, dcen});
    for (int m = 0; m < 4; m++) begin
      wr(ACCR_ADDR_CH0_CONFIG, 32'h0000_8000 | 32'(m));
      chk("cfg", {19'h0, 1'b1, 10'h200, 2'(m)}, {19'h0, dcen, phase, isel});
    end
    $display("channel test done");
    wr(ACCR_ADDR_CH0_OCAL_HI, 32'h0000_A5C3);
    wr(ACCR_ADDR_CH0_OCAL_LO, 32'hFFFF_7EFF);
    rd(ACCR_ADDR_CH0_OCAL_LO, 32'h0000_7E00, 1'b0);
    chk("ocal", 32'h00A5_C37E, {8'h0, ocal});
    $display("offset test done");
    wr(12'h034, 32'h0000_FFFF);
    chk("wr pslverr", 32'h1, {31'h0, e});
    rd(12'h030, 32'h0, 1'b1);
    rd(ACCR_ADDR_CH0_OCAL_HI, 32'h0000_A5C3, 1'b0);
    $display("unmapped test done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    chk("ocal rst", 32'h0, {8'h0, ocal});
    rd(ACCR_ADDR_CH0_OCAL_HI, 32'h0, 1'b0);
    $display("mid reset test done");
    summarize();
  end
endmodule // tb_accr_regs
